//--- logic/lrc_top.sv
/*
 linear regulator control: four regulators, run/standby selection,
 fused defaults, pin control of the second regulator, axi4-lite registers.
 assumes fuse inputs are static after reset and pins are asynchronous.
*/
// Contract
// RQ1: run enable zero keeps regulator off in run
// RQ2: standby enable zero keeps it off in standby
// RQ3: sequenced regulators get enables set, others zero
// RQ4: enable zero means off with pull-down
// RQ5: enable one: regulate, or switch if fused
// RQ6: switch choice comes from fuse only
// RQ7: run code sets voltage in run
// RQ8: standby code sets voltage in standby
// RQ9: both codes load fused default at power-up
// RQ10: code maps to fixed voltage table
// RQ11: pins may drive second regulator on and voltage
// RQ12: load switch follows its switch on bit
// RQ13: state change applies new state settings
`include "lrc_params.svh"
module lrc_top
    import lrc_pkg::*;
#(
    parameter int NUM_REG = `LRC_NUM_REG
)
(
    input wire logic aclk,
    input wire logic aresetn,
    // fused settings, one per regulator
    input wire lrc_fuse_type [NUM_REG-1:0] fuse,
    // pin control of the second regulator, and the standby request pin
    input wire logic second_regulator_on_pin,
    input wire logic voltage_choice_pin,
    input wire logic standby_req_pin,
    // regulator drives
    output lrc_drive_type [NUM_REG-1:0] drive,
    // axi4-lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ========================================
    // software state
    logic [NUM_REG-1:0] run_en_r; // run-state enable bits
    logic [NUM_REG-1:0] stby_en_r; // standby-state enable bits
    logic [NUM_REG-1:0] sw_on_r; // switch on bits
    logic [NUM_REG*4-1:0] run_code_r; // run voltage codes
    logic [NUM_REG*4-1:0] stby_code_r; // standby voltage codes
    logic sw_stby_r; // software standby request
    logic pin_ctrl_r; // second regulator under pin control
    logic init_done_r; // fused defaults loaded

    // ========================================
    // pin synchronisers
    logic [2:0] pins_s; // {standby, choice, on}

    lrc_sync #(.WIDTH(3)) u_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({standby_req_pin, voltage_choice_pin, second_regulator_on_pin}),
        .sync_out(pins_s)
    );

    logic in_standby; // current system state
    assign in_standby = sw_stby_r | pins_s[2];

    // ========================================
    // axi write channel
    logic [11:0] aw_addr_r; // captured write address
    logic aw_held_r; // address held
    logic [31:0] w_data_r; // captured write data
    logic [3:0] w_strb_r; // captured strobes
    logic w_held_r; // data held
    logic wr_fire; // both halves present

    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign wr_fire = aw_held_r && w_held_r;

    // address and data taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else if (wr_fire)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    // decode of a read or write, unmapped gives slverr
    function automatic logic addr_mapped(input logic [11:0] a, input logic wr);
        if (a == `LRC_OFF_ENABLE || a == `LRC_OFF_RUN_VOLT || a == `LRC_OFF_STBY_VOLT)
            addr_mapped = 1'b1;
        else if (a == `LRC_OFF_CTRL)
            addr_mapped = 1'b1;
        else if (a == `LRC_OFF_STATUS || a == `LRC_OFF_OUT_VOLT)
            addr_mapped = !wr;
        else
            addr_mapped = 1'b0;
    endfunction

    // byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        for (int i = 0; i < 4; i++)
        begin
            merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LRC_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_mapped(aw_addr_r, 1'b1) ? `LRC_OKAY : `LRC_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ========================================
    // register images for merging and reading
    logic [31:0] en_img; // enable register view
    logic [31:0] ctrl_img; // control register view
    logic [31:0] status_img; // applied state view
    logic [31:0] outv_img; // applied codes view

    assign en_img = {20'h00000, sw_on_r, stby_en_r, run_en_r};
    assign ctrl_img = {30'h0, pin_ctrl_r, sw_stby_r};

    logic [31:0] en_new; // merged enable write
    logic [31:0] run_new; // merged run codes
    logic [31:0] stby_new; // merged standby codes
    logic [31:0] ctrl_new; // merged control

    assign en_new = merge(en_img, w_data_r, w_strb_r);
    assign run_new = merge({16'h0000, run_code_r}, w_data_r, w_strb_r);
    assign stby_new = merge({16'h0000, stby_code_r}, w_data_r, w_strb_r);
    assign ctrl_new = merge(ctrl_img, w_data_r, w_strb_r);

    // enables: sequence sets them once, then software owns them
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_en_r <= '0;
            stby_en_r <= '0;
            sw_on_r <= '0;
            init_done_r <= 1'b0;
        end
        else if (!init_done_r)
        begin
            for (int i = 0; i < NUM_REG; i++)
            begin
                run_en_r[i] <= fuse[i].in_sequence; // RQ3
                stby_en_r[i] <= fuse[i].in_sequence; // RQ3
                sw_on_r[i] <= fuse[i].in_sequence;
            end
            init_done_r <= 1'b1;
        end
        else if (wr_fire && aw_addr_r == `LRC_OFF_ENABLE)
        begin
            run_en_r <= en_new[`LRC_EN_RUN_LSB +: NUM_REG];
            stby_en_r <= en_new[`LRC_EN_STBY_LSB +: NUM_REG];
            sw_on_r <= en_new[`LRC_EN_SW_LSB +: NUM_REG];
        end
    end

    // voltage codes: fused default into both fields, then software
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_code_r <= '0;
            stby_code_r <= '0;
        end
        else if (!init_done_r)
        begin
            for (int i = 0; i < NUM_REG; i++)
            begin
                run_code_r[i*4 +: 4] <= fuse[i].code; // RQ9
                stby_code_r[i*4 +: 4] <= fuse[i].code; // RQ9
            end
        end
        else if (wr_fire && aw_addr_r == `LRC_OFF_RUN_VOLT)
        begin
            run_code_r <= run_new[NUM_REG*4-1:0];
        end
        else if (wr_fire && aw_addr_r == `LRC_OFF_STBY_VOLT)
        begin
            stby_code_r <= stby_new[NUM_REG*4-1:0];
        end
    end

    // control register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_stby_r <= 1'b0;
            pin_ctrl_r <= 1'b0;
        end
        else if (wr_fire && aw_addr_r == `LRC_OFF_CTRL)
        begin
            sw_stby_r <= ctrl_new[`LRC_CTRL_STBY_BIT];
            pin_ctrl_r <= ctrl_new[`LRC_CTRL_PINSEL_BIT];
        end
    end

    // ========================================
    // per-regulator stages; second one may follow pins
    // pin select picks stored run code or standby code as its two levels
    for (genvar g = 0; g < NUM_REG; g++)
    begin : g_stage
        logic pin_mode; // this regulator under pin control
        logic [3:0] pin_code; // code chosen by the pin
        assign pin_mode = (g == 1) && pin_ctrl_r; // RQ11
        assign pin_code = pins_s[1] ? stby_code_r[g*4 +: 4] : run_code_r[g*4 +: 4]; // RQ11

        lrc_stage u_stage
        (
            .aclk(aclk),
            .aresetn(aresetn),
            .in_standby(pin_mode ? 1'b0 : in_standby),
            .run_en(pin_mode ? pins_s[0] : run_en_r[g]), // RQ11
            .stby_en(stby_en_r[g]),
            .sw_on(pin_mode ? pins_s[0] : sw_on_r[g]), // RQ12
            .run_code(pin_mode ? pin_code : run_code_r[g*4 +: 4]),
            .stby_code(stby_code_r[g*4 +: 4]),
            .switch_mode(fuse[g].switch_mode), // RQ6
            .drive(drive[g])
        );
    end

    // ========================================
    // read channel, answer one cycle after address
    always_comb
    begin
        status_img = 32'h0000_0000;
        outv_img = 32'h0000_0000;
        for (int i = 0; i < NUM_REG; i++)
        begin
            status_img[i*4 +: 3] = drive[i].mode;
            outv_img[i*4 +: 4] = drive[i].code;
        end
        status_img[31] = in_standby;
        status_img[30] = init_done_r;
    end

    assign s_axi_arready = !s_axi_rvalid;

    // read data captured from flip-flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `LRC_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_mapped(s_axi_araddr, 1'b0) ? `LRC_OKAY : `LRC_SLVERR;
            if (s_axi_araddr == `LRC_OFF_ENABLE)
                s_axi_rdata <= en_img;
            else if (s_axi_araddr == `LRC_OFF_RUN_VOLT)
                s_axi_rdata <= {16'h0000, run_code_r};
            else if (s_axi_araddr == `LRC_OFF_STBY_VOLT)
                s_axi_rdata <= {16'h0000, stby_code_r};
            else if (s_axi_araddr == `LRC_OFF_CTRL)
                s_axi_rdata <= ctrl_img;
            else if (s_axi_araddr == `LRC_OFF_STATUS)
                s_axi_rdata <= status_img;
            else if (s_axi_araddr == `LRC_OFF_OUT_VOLT)
                s_axi_rdata <= outv_img;
            else
                s_axi_rdata <= 32'h0000_0000;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

//--- logic/lrc_params.svh
/*
 header of register offsets, field positions, reset values and counts for
 the linear regulator control block.
 assumes it is included by bare name after no other definition of these macros.
*/
`ifndef LRC_PARAMS_SVH
`define LRC_PARAMS_SVH

// ========================================
// register byte offsets
`define LRC_OFF_ENABLE 12'h000
`define LRC_OFF_RUN_VOLT 12'h004
`define LRC_OFF_STBY_VOLT 12'h008
`define LRC_OFF_CTRL 12'h00c
`define LRC_OFF_STATUS 12'h010
`define LRC_OFF_OUT_VOLT 12'h014

// ========================================
// field positions in the enable register
`define LRC_EN_RUN_LSB 0
`define LRC_EN_STBY_LSB 4
`define LRC_EN_SW_LSB 8

// ========================================
// field positions in the control register
`define LRC_CTRL_STBY_BIT 0
`define LRC_CTRL_PINSEL_BIT 1

// ========================================
// reset values and counts
`define LRC_NUM_REG 4
`define LRC_CODE_W 4
`define LRC_SLVERR 2'b10
`define LRC_OKAY 2'b00

`endif

//--- logic/lrc_pkg.sv
/*
 package of types for the linear regulator control block.
 assumes lrc_params.svh sits in the include path.
*/
package lrc_pkg;
    `include "lrc_params.svh"

    // ========================================
    // operating mode of one regulator output stage
    typedef enum logic [2:0]
    {
        LRC_MODE_OFF_PD = 3'b001, // off, output pull-down on
        LRC_MODE_REG = 3'b010, // normal regulation
        LRC_MODE_SWITCH = 3'b100 // pass-through load switch
    } lrc_mode_type;

    // one regulator's drive to the analog stage
    typedef struct packed
    {
        lrc_mode_type mode; // stage mode
        logic [3:0] code; // applied voltage code
        logic [15:0] millivolt; // nominal output for observation
    } lrc_drive_type;

    // fused per-regulator settings
    typedef struct packed
    {
        logic in_sequence; // belongs to power-up sequence
        logic switch_mode; // load switch option
        logic [3:0] code; // default voltage code
    } lrc_fuse_type;
endpackage

//--- logic/lrc_sync.sv
/*
 two flip-flop synchroniser for pin inputs.
 assumes one clock aclk and a synchronous active-low reset.
*/
module lrc_sync
    import lrc_pkg::*;
#(
    parameter int WIDTH = 2
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ========================================
    // first stage is read only by the second
    logic [WIDTH-1:0] meta_r;

    // two stage capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

//--- logic/lrc_stage.sv
/*
 per-regulator mode and voltage decode.
 assumes the enable, code and fuse inputs are already stable on aclk.
*/
module lrc_stage
    import lrc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_standby,
    input wire logic run_en,
    input wire logic stby_en,
    input wire logic sw_on,
    input wire logic [3:0] run_code,
    input wire logic [3:0] stby_code,
    input wire logic switch_mode,
    output lrc_drive_type drive
);
    // ========================================
    // code to millivolts, table lookup
    function automatic logic [15:0] code_to_mv(input logic [3:0] c);
        case (c)
            4'h0: code_to_mv = 16'h05dc;
            4'h1: code_to_mv = 16'h0640;
            4'h2: code_to_mv = 16'h0708;
            4'h3: code_to_mv = 16'h073a;
            4'h4: code_to_mv = 16'h0866;
            4'h5: code_to_mv = 16'h09c4;
            4'h6: code_to_mv = 16'h0af0;
            4'h7: code_to_mv = 16'h0bb8;
            4'h8: code_to_mv = 16'h0c1c;
            4'h9: code_to_mv = 16'h0c4e;
            4'ha: code_to_mv = 16'h0c80;
            4'hb: code_to_mv = 16'h0ce4;
            4'hc: code_to_mv = 16'h0d16;
            4'hd: code_to_mv = 16'h0672;
            4'he: code_to_mv = 16'h06a4;
            default: code_to_mv = 16'h1388;
        endcase
    endfunction

    logic state_en; // enable of the current state
    logic [3:0] code_sel; // code of the current state
    lrc_mode_type mode_nxt; // mode before the register

    // select enable and code of the state now in force
    always_comb
    begin
        state_en = in_standby ? stby_en : run_en; // RQ1 RQ2 RQ13
        code_sel = in_standby ? stby_code : run_code; // RQ7 RQ8 RQ13
        if (!state_en)
        begin
            mode_nxt = LRC_MODE_OFF_PD; // RQ4
        end
        else if (!switch_mode)
        begin
            mode_nxt = LRC_MODE_REG; // RQ5
        end
        else
        begin
            // switch closes only with its own on bit
            mode_nxt = sw_on ? LRC_MODE_SWITCH : LRC_MODE_OFF_PD; // RQ5 RQ12
        end
    end

    // registered drive, safe off after reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            drive <= '{mode: LRC_MODE_OFF_PD, code: 4'h0, millivolt: 16'h0000};
        end
        else
        begin
            drive.mode <= mode_nxt;
            drive.code <= code_sel;
            drive.millivolt <= code_to_mv(code_sel); // RQ10
        end
    end
endmodule

//--- verif/lrc_top_chk.sv
/*
 checker for the linear regulator control top: bus answer timing and drive decode.
 assumes it is bound to lrc_top and sees only that module's ports.
*/
module lrc_top_chk
    import lrc_pkg::*;
#(
    parameter int NUM_REG = 4
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire lrc_fuse_type [NUM_REG-1:0] fuse,
    input wire lrc_drive_type [NUM_REG-1:0] drive,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ========================================
    // one clock domain, so clock and reset are given once
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // nominal millivolts per voltage code, kept apart from the design's table
    localparam logic [15:0] MV_TAB [16] = '{16'h05dc, 16'h0640, 16'h0708, 16'h073a, 16'h0866, 16'h09c4,
        16'h0af0, 16'h0bb8, 16'h0c1c, 16'h0c4e, 16'h0c80, 16'h0ce4, 16'h0d16, 16'h0672, 16'h06a4, 16'h1388};

    // mode expected straight after power-up from the fused settings
    function automatic lrc_mode_type boot_mode(input lrc_fuse_type f);
        if (!f.in_sequence)
            return LRC_MODE_OFF_PD;
        return f.switch_mode ? LRC_MODE_SWITCH : LRC_MODE_REG;
    endfunction

    // ========================================
    // bus handshake steps
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_wr_answer_gap: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response not two cycles after the write was taken");
    a_b_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before it was taken");
    a_rd_answer_gap: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data not one cycle after the address was taken");
    a_r_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before it was taken");
    a_rd_unmapped_err: assert property (rd_taken ##0 (s_axi_araddr > 12'h014) |=> s_axi_rresp == 2'b10)
        else $error("unmapped read did not answer with slave error");

    // ========================================
    // per-regulator drive decode
    for (genvar i = 0; i < NUM_REG; i++)
    begin : g_reg
        a_mv_code_table: assert property (
            drive[i].mode != LRC_MODE_OFF_PD |-> drive[i].millivolt == MV_TAB[drive[i].code])
            else $error("output millivolts do not match the voltage code");
        a_switch_needs_fuse: assert property (
            drive[i].mode == LRC_MODE_SWITCH |-> fuse[i].switch_mode)
            else $error("load switch mode without the fused option");
        a_regulate_no_fuse: assert property (
            drive[i].mode == LRC_MODE_REG |-> !fuse[i].switch_mode)
            else $error("regulation mode although the switch option is fused");
        a_boot_defaults: assert property (
            $rose(aresetn) |-> ##2 (drive[i].mode == boot_mode(fuse[i]) &&
            (!fuse[i].in_sequence || drive[i].code == fuse[i].code)))
            else $error("power-up enables or codes differ from the fused defaults");
    end
endmodule

bind lrc_top lrc_top_chk #(.NUM_REG(NUM_REG)) chk_u (.aclk(aclk), .aresetn(aresetn), .fuse(fuse), .drive(drive),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

//--- verif/lrc_top_tb_top.sv
/*
 self-checking bench for the linear regulator control top.
 assumes the checker file is compiled alongside and binds itself.
*/
module lrc_top_tb_top
    import lrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================
    // one table row: register settings beside expected modes and codes
    typedef struct packed
    {
        logic [11:0] en;
        logic [15:0] run;
        logic [15:0] stby;
        logic sb;
        logic [11:0] mode;
        logic [15:0] code;
    } lrc_row_type;

    logic aclk;
    logic aresetn = 1'b0;
    lrc_fuse_type [3:0] fuse = 24'hfdd963; // regs 2,3 fused as switch, reg 2 outside the sequence
    logic on_pin = 1'b0;
    logic sel_pin = 1'b0;
    logic sb_pin = 1'b0;
    lrc_drive_type [3:0] drive;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf; // byte lanes of a write
    logic [31:0] rdata;
    logic [31:0] rd;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [1:0] resp;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    int lag = 0; // cycles the master waits before taking an answer
    lrc_row_type rows [7];

    lrc_top dut_u (.aclk(aclk), .aresetn(aresetn), .fuse(fuse), .second_regulator_on_pin(on_pin),
        .voltage_choice_pin(sel_pin), .standby_req_pin(sb_pin), .drive(drive), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ========================================
    // clock and hang guard
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // a run far past the expected few hundred cycles is a hang
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            close_out();
        end
    end

    // ========================================
    // comparison, bus and drive tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (lag == 0);
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while ((awvalid & ~awready) | (wvalid & ~wready));
        repeat (lag) @(posedge aclk);
        bready <= 1'b1;
        do
            @(posedge aclk);
        while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_t(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (lag == 0);
        do
            @(posedge aclk);
        while (arready !== 1'b1);
        arvalid <= 1'b0;
        repeat (lag) @(posedge aclk);
        rready <= 1'b1;
        do
            @(posedge aclk);
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // program enables, both code sets and control, then let the drive settle
    task automatic put(input logic [11:0] en, input logic [15:0] run, input logic [15:0] stby, input logic [1:0] ctl);
        wr(12'h000, {20'h0, en}, resp);
        wr(12'h004, {16'h0, run}, resp);
        wr(12'h008, {16'h0, stby}, resp);
        wr(12'h00c, {30'h0, ctl}, resp);
        chk("bresp", {30'h0, resp}, 32'h0);
        repeat (4) @(posedge aclk);
    endtask

    // codes are only meaningful where the regulator is on
    task automatic see(input logic [11:0] m, input logic [15:0] c);
        for (int i = 0; i < 4; i++)
        begin
            chk("mode", {29'h0, drive[i].mode}, {29'h0, m[3*i+:3]});
            if (m[3*i+:3] != 3'b001)
                chk("code", {28'h0, drive[i].code}, {28'h0, c[4*i+:4]});
        end
    endtask

    task automatic close_out();
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ========================================
    // main sequence
    initial
    begin
        rows = '{'{12'hfff, 16'h3210, 16'h7654, 1'b0, 12'h912, 16'h3210},
            '{12'hfff, 16'h3210, 16'h7654, 1'b1, 12'h912, 16'h7654},
            '{12'h0f0, 16'hba98, 16'hfedc, 1'b1, 12'h252, 16'hfedc},
            '{12'h0f0, 16'hba98, 16'hfedc, 1'b0, 12'h249, 16'h0000},
            '{12'hf0f, 16'hba98, 16'hfedc, 1'b1, 12'h249, 16'h0000},
            '{12'hf0f, 16'hba98, 16'hfedc, 1'b0, 12'h912, 16'hba98},
            '{12'hc0f, 16'hfedc, 16'h0000, 1'b0, 12'h912, 16'hfedc}};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        // table rows move between run and standby every step or two
        foreach (rows[k])
        begin
            put(rows[k].en, rows[k].run, rows[k].stby, {1'b0, rows[k].sb});
            see(rows[k].mode, rows[k].code);
            rd_t(12'h000, rd, resp);
            chk("enable", rd, {20'h0, rows[k].en});
        end
        // pin control of the second regulator
        put(12'hfff, 16'h3210, 16'h7654, 2'b10);
        see(12'h90a, 16'h3210);
        on_pin <= 1'b1;
        repeat (5) @(posedge aclk);
        see(12'h912, 16'h3210);
        sel_pin <= 1'b1;
        repeat (5) @(posedge aclk);
        see(12'h912, 16'h3250);
        sel_pin <= 1'b0;
        sb_pin <= 1'b1;
        repeat (5) @(posedge aclk);
        see(12'h912, 16'h7614);
        sb_pin <= 1'b0;
        on_pin <= 1'b0;
        // late bready and rready on a one-lane write: answers stand, other lanes kept
        lag = 3;
        wstrb <= 4'h1;
        wr(12'h004, 32'h0000_5a3c, resp);
        chk("late bresp", {30'h0, resp}, 32'h0);
        rd_t(12'h004, rd, resp);
        chk("late rdata", rd, 32'h0000_323c);
        lag = 0;
        wstrb <= 4'hf;
        // read-only and unmapped places answer with slave error
        wr(12'h010, 32'hffffffff, resp);
        chk("ro bresp", {30'h0, resp}, 32'h2);
        wr(12'h018, 32'h0, resp);
        chk("unmapped bresp", {30'h0, resp}, 32'h2);
        rd_t(12'h018, rd, resp);
        chk("unmapped rresp", {30'h0, resp}, 32'h2);
        // second reset in mid-run brings back the fused defaults
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        rd_t(12'h000, rd, resp);
        chk("boot enable", rd, 32'hbbb);
        rd_t(12'h004, rd, resp);
        chk("boot run code", rd, 32'hfd53);
        rd_t(12'h008, rd, resp);
        chk("boot standby code", rd, 32'hfd53);
        rd_t(12'h010, rd, resp);
        chk("boot status", rd, 32'h4000_4122);
        see(12'h852, 16'hfd53);
        close_out();
    end
endmodule
